// [hdl/ssr_pkg.sv]
package ssr_pkg;
	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int AW        = 8;         // APB address width
	localparam int DW        = 32;        // APB data width
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] A_CTRL     = 8'h00; // Write-only commands
	localparam logic [7:0] A_CFG      = 8'h04; // Mode and framing
	localparam logic [7:0] A_BAUD     = 8'h08; // Clocks per bit
	localparam logic [7:0] A_START    = 8'h0c; // Table start address
	localparam logic [7:0] A_RXCHR    = 8'h10; // Characters received
	localparam logic [7:0] A_TXCHR    = 8'h14; // Characters transmitted
	localparam logic [7:0] A_TXPCT    = 8'h18; // Transmit utilisation
	localparam logic [7:0] A_RXPCT    = 8'h1c; // Receive utilisation
	localparam logic [7:0] A_ROUTE_LO = 8'h20; // Last route slots 0..3
	localparam logic [7:0] A_ROUTE_HI = 8'h24; // Last route slots 4..7
	localparam logic [7:0] A_CHDLY    = 8'h28; // Channel delay bytes
	localparam logic [7:0] A_QUEUED   = 8'h2c; // Messages queued
	localparam logic [7:0] A_BUFUSE   = 8'h30; // Buffers in use
	localparam logic [7:0] A_PADCNT   = 8'h34; // Pad count control
	localparam logic [7:0] A_TIDX     = 8'h38; // Table index
	localparam logic [7:0] A_TLO      = 8'h3c; // Entry drops 0..3
	localparam logic [7:0] A_THI      = 8'h40; // Entry drops 4..7
	localparam logic [7:0] A_TMETA    = 8'h44; // Entry length/type, commit
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_ZERO    = 0;      // Zero statistics
	localparam int CTRL_AVGRST  = 1;      // Restart averages
	localparam int CFG_SLAVE    = 0;      // Slave mode enable
	localparam int CFG_DBITS    = 2;      // Data bits minus 5, 2 bits
	localparam int CFG_PAR      = 4;      // Parity bit present
	localparam int CFG_STOP2    = 5;      // Two stop bits
	localparam int META_TYPE    = 4;      // 1 = Modbus target
	localparam logic [5:0]  CFG_RST   = 6'h0c;   // 8 data, no parity, 1 stop
	localparam logic [15:0] BAUD_RST  = 16'h1458; // 9600 baud at 50 MHz
	localparam logic [7:0]  START_RST = 8'h01;
	localparam logic [7:0]  START_MAX = 8'h81;    // Highest start address 129
	localparam logic [7:0]  SLOT_NONE = 8'hff;    // Unused route slot
	// ----------------------------------------
	// Table and route shape
	// ----------------------------------------
	localparam int DROPS  = 8;            // Drops per route
	localparam int TBL_N  = 128;          // Entries per table
	localparam int TIX_W  = 7;            // Table index width
	localparam int LEN_W  = 4;            // Route length width
	localparam int RT_W   = DROPS * 8;    // Packed route width
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ       = 50_000_000;
	localparam int FAULT_MS     = 1000;   // Fault lamp time in ms
	localparam int FAULT_CYC    = FAULT_MS * (CLK_HZ / 1000);
	localparam int AVG_SHIFT    = 20;     // Interval is 2**20 clocks
	localparam int PCT_SCALE    = 100;    // Percent scale
	localparam int CNT_W        = 8;      // Queue counter width
	// Pad count is delay plus this margin
	localparam int PAD_MARGIN   = 10;
	// Channel delay tracker states
	typedef enum logic [0:0] {CD_IDLE, CD_WAIT} ssr_cd_e;
endpackage : ssr_pkg

// [hdl/ssr_port.sv]
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
// Summary of operation
// R1: Count every received serial byte
// R2: Average transmit utilisation including framing bits
// R3: Average receive utilisation including framing bits
// R4: Zero, port change, page entry restart averages
// R5: Store last message route in eight slots
// R6: Slots past route end marked unused
// R7: Slots read zero before any message
// R8: Count bytes sent between checksum and ack
// R9: Host writes delay plus ten to pad
// R10: Report messages queued for transmission
// R11: Report buffers currently occupied
// R12: Slave mode selects entry by address
// R13: Non-empty entry yields routed message
// R14: Empty entry discards request silently
// R15: Own table, 128 entries, eight drops
// R16: Table covers 128 addresses from start
// R17: Entry type selects Modbus or other
// R18: Configurer makes first drop this port
// R19: Error lights both fault lamps one second
// R20: Out-of-range addresses ignored like empty
module ssr_port #(
	parameter int FAULT_CYC = ssr_pkg::FAULT_CYC, // Fault lamp hold
	parameter int Q_W       = ssr_pkg::CNT_W      // Occupancy width
) (
	// Clock, reset, enable
	input  wire logic                       CLK,
	input  wire logic                       NRST,
	input  wire logic                       CE,
	// APB slave
	input  wire logic                       PSEL,
	input  wire logic                       PENABLE,
	input  wire logic                       PWRITE,
	input  wire logic [ssr_pkg::AW-1:0]     PADDR,
	input  wire logic [ssr_pkg::DW-1:0]     PWDATA,
	output logic      [ssr_pkg::DW-1:0]     PRDATA,
	output logic                            PREADY,
	output logic                            PSLVERR,
	// Serial character events
	input  wire logic                       RX_CHAR_STB,
	input  wire logic                       TX_CHAR_STB,
	input  wire logic                       CKSUM_SENT,
	input  wire logic                       ACK_SEEN,
	// Incoming routed message
	input  wire logic                       MSG_STB,
	input  wire logic [ssr_pkg::LEN_W-1:0]  MSG_LEN,
	input  wire logic [ssr_pkg::RT_W-1:0]   MSG_ROUTE,
	// Buffer and queue events
	input  wire logic                       Q_PUSH,
	input  wire logic                       Q_POP,
	input  wire logic                       BUF_TAKE,
	input  wire logic                       BUF_FREE,
	// Slave request from serial master
	input  wire logic                       REQ_VALID,
	input  wire logic [7:0]                 REQ_ADDR,
	// Translated request toward network
	output logic                            FWD_VALID,
	output logic [ssr_pkg::LEN_W-1:0]       FWD_LEN,
	output logic [ssr_pkg::RT_W-1:0]        FWD_ROUTE,
	output logic                            FWD_MODBUS,
	output logic                            REQ_DROP,
	// Error events and lamps
	input  wire logic                       ERR_STB,
	output logic                            FAULT_RED,
	output logic                            FAULT_GREEN,
	// Pad count to transmitter
	output logic [15:0]                     PAD_COUNT
);
	import ssr_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Up/down counter that never wraps
	function automatic logic [Q_W-1:0] updn(input logic [Q_W-1:0] c,
		input logic up, input logic dn);
		logic [Q_W-1:0] r;
		r = c;
		if (up && !dn && c != {Q_W{1'b1}}) begin
			r = c + 1'b1;
		end else if (dn && !up && c != '0) begin
			r = c - 1'b1;
		end
		return r;
	endfunction : updn

	// Busy clocks in one interval as percent of it
	function automatic logic [15:0] pct(input logic [31:0] busy);
		logic [38:0] p;
		p = {7'h00, busy} * 39'(PCT_SCALE);
		return p[AVG_SHIFT+15:AVG_SHIFT];
	endfunction : pct

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [5:0]       cfg_r;        // Mode and framing
	logic [15:0]      baud_r;       // Clocks per bit
	logic [7:0]       start_r;      // First covered address
	logic [15:0]      pad_r;        // Pad count control
	logic [TIX_W-1:0] tidx_r;       // Table access index
	logic [RT_W-1:0]  tstage_r;     // Staged entry route
	logic [31:0]      rxchr_r;      // Received characters
	logic [31:0]      txchr_r;      // Transmitted characters
	logic [RT_W-1:0]  last_rt_r;    // Last route slots
	logic [31:0]      chdly_r;      // Last channel delay
	logic [31:0]      cd_acc_r;     // Delay bytes in progress
	ssr_cd_e          cd_st_r;      // Delay tracker state
	logic [Q_W-1:0]   queued_r;     // Messages waiting
	logic [Q_W-1:0]   bufuse_r;     // Buffers held
	logic [AVG_SHIFT-1:0] ivl_r;    // Interval timer
	logic [31:0]      txbusy_r;     // Tx busy clocks this interval
	logic [31:0]      rxbusy_r;     // Rx busy clocks this interval
	logic [15:0]      txpct_r;      // Tx average
	logic [15:0]      rxpct_r;      // Rx average
	logic             avg_first_r;  // Next sample seeds the average
	logic [31:0]      fault_r;      // Fault lamp timer
	// Entry: type, length, route; length zero means empty
	logic [RT_W+LEN_W:0] tbl [TBL_N];

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire bus_wr  = CE && PSEL && PENABLE && PWRITE;
	wire bus_set = CE && PSEL && !PENABLE;
	wire [7:0] wa = PADDR;
	wire zero_cmd  = bus_wr && wa == A_CTRL && PWDATA[CTRL_ZERO];
	// Zeroing also restarts the averages; page entry and port change
	// are signalled by the restart bit
	wire avg_rst   = zero_cmd || (bus_wr && wa == A_CTRL && PWDATA[CTRL_AVGRST]); // R4
	wire [RT_W+LEN_W:0] tent = tbl[tidx_r];
	wire mapped = wa[1:0] == 2'b00 && wa <= A_TMETA;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [DW-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (wa)
			A_CFG:      rd_mux = {26'h0, cfg_r};
			A_BAUD:     rd_mux = {16'h0, baud_r};
			A_START:    rd_mux = {24'h0, start_r};
			A_RXCHR:    rd_mux = rxchr_r;
			A_TXCHR:    rd_mux = txchr_r;
			A_TXPCT:    rd_mux = {16'h0, txpct_r};
			A_RXPCT:    rd_mux = {16'h0, rxpct_r};
			A_ROUTE_LO: rd_mux = last_rt_r[31:0];
			A_ROUTE_HI: rd_mux = last_rt_r[63:32];
			A_CHDLY:    rd_mux = chdly_r;
			A_QUEUED:   rd_mux = 32'(queued_r);   // R10
			A_BUFUSE:   rd_mux = 32'(bufuse_r);   // R11
			A_PADCNT:   rd_mux = {16'h0, pad_r};
			A_TIDX:     rd_mux = 32'(tidx_r);
			A_TLO:      rd_mux = tent[31:0];
			A_THI:      rd_mux = tent[63:32];
			A_TMETA:    rd_mux = {27'h0, tent[RT_W+LEN_W], tent[RT_W+LEN_W-1:RT_W]};
			default:    rd_mux = '0;
		endcase
	end

	// Zero wait states: every access completes in one access cycle
	assign PREADY = 1'b1;

	// Read data and error are sampled in the setup cycle
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			PRDATA  <= '0;
			PSLVERR <= 1'b0;
		end else if (bus_set) begin
			PRDATA  <= PWRITE ? '0 : rd_mux;
			PSLVERR <= !mapped;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Start address is clamped to its legal top
	wire [7:0] start_nxt = (PWDATA[7:0] > START_MAX) ? START_MAX : PWDATA[7:0]; // R16
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cfg_r    <= CFG_RST;
			baud_r   <= BAUD_RST;
			start_r  <= START_RST;
			pad_r    <= 16'h0000;
			tidx_r   <= '0;
			tstage_r <= '0;
		end else if (bus_wr) begin
			case (wa)
				A_CFG:   cfg_r    <= PWDATA[5:0];
				A_BAUD:  baud_r   <= PWDATA[15:0];
				A_START: start_r  <= start_nxt;
				A_PADCNT: pad_r   <= PWDATA[15:0];     // R9
				A_TIDX:  tidx_r   <= PWDATA[TIX_W-1:0];
				A_TLO:   tstage_r[31:0]  <= PWDATA;
				A_THI:   tstage_r[63:32] <= PWDATA;
				default: ;
			endcase
		end
	end
	assign PAD_COUNT = pad_r;

	// Table write; no reset, software fills entries before slave use
	always_ff @(posedge CLK) begin
		if (bus_wr && wa == A_TMETA) begin
			tbl[tidx_r] <= {PWDATA[META_TYPE], PWDATA[LEN_W-1:0], tstage_r}; // R15 R17
		end
	end

	// ----------------------------------------
	// Character counters and channel delay
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rxchr_r  <= '0;
			txchr_r  <= '0;
			chdly_r  <= '0;
			cd_acc_r <= '0;
			cd_st_r  <= CD_IDLE;
		end else if (CE) begin
			// A byte landing with the zero command survives as the first count
			rxchr_r <= zero_cmd ? 32'(RX_CHAR_STB) : rxchr_r + 32'(RX_CHAR_STB); // R1
			txchr_r <= zero_cmd ? 32'(TX_CHAR_STB) : txchr_r + 32'(TX_CHAR_STB);
			case (cd_st_r)
				CD_IDLE: begin
					if (CKSUM_SENT) begin
						cd_acc_r <= '0;
						cd_st_r  <= CD_WAIT;
					end
				end
				CD_WAIT: begin
					// Pads and enquiries both arrive as sent bytes
					if (ACK_SEEN) begin
						chdly_r <= cd_acc_r + 32'(TX_CHAR_STB); // R8
						cd_st_r <= CD_IDLE;
					end else begin
						cd_acc_r <= cd_acc_r + 32'(TX_CHAR_STB); // R8
					end
				end
				default: cd_st_r <= CD_IDLE;
			endcase
			if (zero_cmd) begin
				chdly_r <= '0;
			end
		end
	end

	// ----------------------------------------
	// Utilisation averages
	// ----------------------------------------
	// Clocks one character occupies: start, data, parity, stops
	// One start, five plus field data, parity, one or two stops
	wire [3:0]  char_bits = 4'd7 + 4'(cfg_r[CFG_DBITS+:2]) + 4'(cfg_r[CFG_PAR])
		+ 4'(cfg_r[CFG_STOP2]);
	wire [31:0] char_cyc  = 32'(baud_r * char_bits);
	wire        ivl_end   = &ivl_r;
	wire [15:0] tx_s      = pct(txbusy_r);
	wire [15:0] rx_s      = pct(rxbusy_r);
	// Halving average keeps history short but needs no divider;
	// a busy line can read above full scale near interval edges
	wire [15:0] tx_avg_nxt = avg_first_r ? tx_s : 16'((17'(txpct_r) + 17'(tx_s)) >> 1);
	wire [15:0] rx_avg_nxt = avg_first_r ? rx_s : 16'((17'(rxpct_r) + 17'(rx_s)) >> 1);
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ivl_r       <= '0;
			txbusy_r    <= '0;
			rxbusy_r    <= '0;
			txpct_r     <= '0;
			rxpct_r     <= '0;
			avg_first_r <= 1'b1;
		end else if (CE) begin
			if (avg_rst) begin
				ivl_r       <= '0;                  // R4
				txbusy_r    <= '0;
				rxbusy_r    <= '0;
				txpct_r     <= '0;
				rxpct_r     <= '0;
				avg_first_r <= 1'b1;
			end else begin
				ivl_r    <= ivl_r + 1'b1;
				txbusy_r <= (ivl_end ? '0 : txbusy_r) + (TX_CHAR_STB ? char_cyc : '0); // R2
				rxbusy_r <= (ivl_end ? '0 : rxbusy_r) + (RX_CHAR_STB ? char_cyc : '0); // R3
				if (ivl_end) begin
					txpct_r     <= tx_avg_nxt;       // R2
					rxpct_r     <= rx_avg_nxt;       // R3
					avg_first_r <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Last route received
	// ----------------------------------------
	logic [RT_W-1:0] rt_mask;
	genvar gi;
	generate
		for (gi = 0; gi < DROPS; gi++) begin : g_slot
			// Slot beyond length shows unused marker
			assign rt_mask[gi*8+:8] = (gi < MSG_LEN) ? MSG_ROUTE[gi*8+:8] : SLOT_NONE; // R6
		end
	endgenerate
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			last_rt_r <= '0;                         // R7
		end else if (CE && MSG_STB) begin
			last_rt_r <= rt_mask;                    // R5
		end
	end

	// ----------------------------------------
	// Queue and buffer occupancy
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			queued_r <= '0;
			bufuse_r <= '0;
		end else if (CE) begin
			queued_r <= updn(queued_r, Q_PUSH, Q_POP);     // R10
			bufuse_r <= updn(bufuse_r, BUF_TAKE, BUF_FREE); // R11
		end
	end

	// ----------------------------------------
	// Slave address look-up
	// ----------------------------------------
	wire [7:0] rel      = REQ_ADDR - start_r;
	wire       in_range = REQ_ADDR >= start_r && rel < 8'(TBL_N);  // R16 R20
	wire [RT_W+LEN_W:0] sel = tbl[rel[TIX_W-1:0]];                 // R12
	wire       hit      = in_range && sel[RT_W+LEN_W-1:RT_W] != '0;
	wire       take     = CE && REQ_VALID && cfg_r[CFG_SLAVE];     // R12
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			FWD_VALID  <= 1'b0;
			FWD_LEN    <= '0;
			FWD_ROUTE  <= '0;
			FWD_MODBUS <= 1'b0;
			REQ_DROP   <= 1'b0;
		end else if (CE) begin
			FWD_VALID <= take && hit;                  // R13
			REQ_DROP  <= take && !hit;                 // R14 R20
			if (take && hit) begin
				FWD_LEN    <= sel[RT_W+LEN_W-1:RT_W];  // R13
				FWD_ROUTE  <= sel[RT_W-1:0];
				FWD_MODBUS <= sel[RT_W+LEN_W];         // R17
			end
		end
	end

	// ----------------------------------------
	// Fault lamps
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			fault_r     <= '0;
			FAULT_RED   <= 1'b0;
			FAULT_GREEN <= 1'b0;
		end else if (CE) begin
			// New error restarts the full hold
			if (ERR_STB) begin
				fault_r <= 32'(FAULT_CYC - 1);         // R19
			end else if (fault_r != '0) begin
				fault_r <= fault_r - 1'b1;
			end
			FAULT_RED   <= ERR_STB || fault_r != '0;   // R19
			FAULT_GREEN <= ERR_STB || fault_r != '0;
		end
	end
endmodule : ssr_port

// [verif/ssr_port_assertions.sv]
`timescale 1ns/100ps
module ssr_port_assertions
	import ssr_pkg::*;
#(
	parameter int FAULT_CYC = 20 // Lamp hold in clocks
) (
	// Clock and reset
	input wire logic                 CLK,
	input wire logic                 NRST,
	// Register bus
	input wire logic                 PSEL,
	input wire logic                 PENABLE,
	input wire logic                 PWRITE,
	input wire logic [AW-1:0]        PADDR,
	input wire logic                 PREADY,
	input wire logic [15:0]          PAD_COUNT,
	// Lookup
	input wire logic                 REQ_VALID,
	input wire logic                 FWD_VALID,
	input wire logic [LEN_W-1:0]     FWD_LEN,
	input wire logic [RT_W-1:0]      FWD_ROUTE,
	input wire logic                 REQ_DROP,
	// Fault lamps
	input wire logic                 ERR_STB,
	input wire logic                 FAULT_RED,
	input wire logic                 FAULT_GREEN
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	// ----------------------------------------
	// Cycles since last error strobe
	// ----------------------------------------
	int since_err_r;   // Saturates one past the hold
	int since_err_nxt; // Zero means never struck
	assign since_err_nxt = ERR_STB ? 1 :
		(since_err_r != 0 && since_err_r <= FAULT_CYC) ? since_err_r + 1 : since_err_r;
	// Counter update
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			since_err_r <= 0;
		end else begin
			since_err_r <= since_err_nxt;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_fwd_cause; FWD_VALID |-> $past(REQ_VALID); endproperty
	a_fwd_cause: assert property (p_fwd_cause) else $error("forward without request");
	property p_drop_cause; REQ_DROP |-> $past(REQ_VALID); endproperty
	a_drop_cause: assert property (p_drop_cause) else $error("drop without request");
	property p_excl; !(FWD_VALID && REQ_DROP); endproperty
	a_excl: assert property (p_excl) else $error("forward and drop together");
	property p_fwd_len; FWD_VALID |-> FWD_LEN != 0 && FWD_LEN <= DROPS; endproperty
	a_fwd_len: assert property (p_fwd_len) else $error("forward of empty entry");
	property p_fwd_hold; $changed(FWD_ROUTE) |-> FWD_VALID; endproperty
	a_fwd_hold: assert property (p_fwd_hold) else $error("route moved without hit");
	property p_lamp_on; ERR_STB |=> FAULT_RED && FAULT_GREEN; endproperty
	a_lamp_on: assert property (p_lamp_on) else $error("lamps not lit");
	property p_lamp_pair; FAULT_RED == FAULT_GREEN; endproperty
	a_lamp_pair: assert property (p_lamp_pair) else $error("lamps disagree");
	property p_lamp_time; FAULT_RED |-> since_err_r inside {[1:FAULT_CYC]}; endproperty
	a_lamp_time: assert property (p_lamp_time) else $error("lamp lit too long");
	property p_pad; $changed(PAD_COUNT) |-> $past(PSEL && PENABLE && PWRITE); endproperty
	a_pad: assert property (p_pad) else $error("pad count moved alone");
	property p_ready; PSEL && PENABLE |-> PREADY; endproperty
	a_ready: assert property (p_ready) else $error("bus stalled");
endmodule : ssr_port_assertions
bind ssr_port ssr_port_assertions #(.FAULT_CYC(FAULT_CYC)) u_chk (.CLK(CLK), .NRST(NRST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY),
	.PAD_COUNT(PAD_COUNT), .REQ_VALID(REQ_VALID), .FWD_VALID(FWD_VALID), .FWD_LEN(FWD_LEN),
	.FWD_ROUTE(FWD_ROUTE), .REQ_DROP(REQ_DROP), .ERR_STB(ERR_STB), .FAULT_RED(FAULT_RED),
	.FAULT_GREEN(FAULT_GREEN));

// [verif/ssr_master_model.sv]
`timescale 1ns/100ps
module ssr_master_model (
	// Clock
	input  wire logic CLK,
	// Slave request
	output logic      REQ_VALID,
	output logic [7:0] REQ_ADDR
);
	// Idle address is the inverse of the last one, never a stale copy
	initial begin
		REQ_VALID = 1'b0;
		REQ_ADDR  = 8'h00;
	end
	// One request, one clock wide
	task automatic send(input logic [7:0] a);
		@(posedge CLK);
		REQ_VALID <= 1'b1;
		REQ_ADDR  <= a;
		@(posedge CLK);
		REQ_VALID <= 1'b0;
		REQ_ADDR  <= ~a;
	endtask : send
endmodule : ssr_master_model

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
	import ssr_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, rerr;
	logic        rx, tx, cks, ack, msg, qpu, qpo, bt, bf, reqv, fv, fm, drp, err, fr, fg;
	logic [7:0]  paddr, req_addr;
	logic [31:0] pwdata, prdata, rdata;
	logic [3:0]  mlen, flen;
	logic [63:0] mroute, froute;
	logic [15:0] pad;
	int          n_fail, checked;
	// Event strobes live in one vector so one task can pulse any of them
	localparam int EV_RX = 0, EV_TX = 1, EV_CKS = 2, EV_ACK = 3, EV_MSG = 4;
	localparam int EV_QPU = 5, EV_QPO = 6, EV_BT = 7, EV_BF = 8, EV_ERR = 9;
	logic [9:0]  ev;
	assign {err, bf, bt, qpo, qpu, msg, ack, cks, tx, rx} = ev;
	// Short lamp hold keeps the run brief
	ssr_port #(.FAULT_CYC(20)) u_dut (.CLK(clk), .NRST(nrst), .CE(1'b1), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .RX_CHAR_STB(rx), .TX_CHAR_STB(tx),
		.CKSUM_SENT(cks), .ACK_SEEN(ack), .MSG_STB(msg), .MSG_LEN(mlen), .MSG_ROUTE(mroute),
		.Q_PUSH(qpu), .Q_POP(qpo), .BUF_TAKE(bt), .BUF_FREE(bf), .REQ_VALID(reqv),
		.REQ_ADDR(req_addr), .FWD_VALID(fv), .FWD_LEN(flen), .FWD_ROUTE(froute),
		.FWD_MODBUS(fm), .REQ_DROP(drp), .ERR_STB(err), .FAULT_RED(fr), .FAULT_GREEN(fg),
		.PAD_COUNT(pad));
	ssr_master_model u_master (.CLK(clk), .REQ_VALID(reqv), .REQ_ADDR(req_addr));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	// One bus transfer, waits on ready with a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk);
		end
		if (n == 50) n_fail++;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		chk({rerr, rdata}, {1'b0, e}, m);
	endtask : rdc
	// One-clock strobe on event bit k, n times with a gap
	task automatic pulse(input int k, input int n);
		repeat (n) begin
			@(posedge clk);
			ev[k] <= 1'b1;
			@(posedge clk);
			ev[k] <= 1'b0;
		end
	endtask : pulse
	task automatic ent(input logic [31:0] i, input logic [63:0] r, input logic [31:0] m);
		apb(1'b1, A_TIDX, i);
		apb(1'b1, A_TLO, r[31:0]);
		apb(1'b1, A_THI, r[63:32]);
		apb(1'b1, A_TMETA, m);
	endtask : ent
	// Request, then look at the answer one clock later
	task automatic req(input logic [7:0] a, input logic f, input logic d);
		u_master.send(a);
		#1;
		chk({fv, drp}, {f, d}, "lookup answer");
	endtask : req
	task automatic msgc(input logic [3:0] l, input logic [31:0] lo, input logic [31:0] hi);
		mlen <= l;
		mroute <= 64'h0807060504030201;
		pulse(EV_MSG, 1);
		rdc(A_ROUTE_LO, lo, "route lo");
		rdc(A_ROUTE_HI, hi, "route hi");
	endtask : msgc
	task tally_and_finish;
		if (n_fail == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#1_000_000;
		n_fail++;
		tally_and_finish();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{nrst, psel, penable, pwrite} = '0;
		ev = '0;
		{paddr, pwdata, mlen, mroute} = '0;
		n_fail = 0;
		checked = 0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rdc(A_CFG, 32'h0c, "cfg reset");
		rdc(A_START, 32'h01, "start reset");
		rdc(A_ROUTE_LO, 32'h0, "route before msg");
		rdc(A_ROUTE_HI, 32'h0, "route before msg");
		apb(1'b0, 8'h48, 32'h0);
		chk({rerr, rdata}, {1'b1, 32'h0}, "unmapped read");
		pulse(EV_RX, 5);
		rdc(A_RXCHR, 32'd5, "rx chars");
		pulse(EV_TX, 3);
		pulse(EV_CKS, 1);
		pulse(EV_TX, 4);
		pulse(EV_ACK, 1);
		rdc(A_TXCHR, 32'd7, "tx chars");
		rdc(A_CHDLY, 32'd4, "channel delay");
		apb(1'b1, A_PADCNT, rdata + PAD_MARGIN);
		@(posedge clk);
		#1;
		chk(pad, 16'd14, "pad count");
		apb(1'b1, A_CTRL, 32'h1);
		rdc(A_RXCHR, 32'h0, "zeroed rx");
		rdc(A_TXPCT, 32'h0, "tx average restart");
		rdc(A_RXPCT, 32'h0, "rx average restart");
		rdc(A_TXCHR, 32'h0, "zeroed tx");
		pulse(EV_RX, 2);
		apb(1'b1, A_CTRL, 32'h2);
		rdc(A_RXCHR, 32'd2, "restart keeps count");
		rdc(A_RXPCT, 32'h0, "rx average restart only");
		msgc(4'd3, 32'hff030201, 32'hffffffff);
		msgc(4'd8, 32'h04030201, 32'h08070605);
		msgc(4'd0, 32'hffffffff, 32'hffffffff);
		pulse(EV_QPU, 3);
		pulse(EV_QPO, 1);
		rdc(A_QUEUED, 32'd2, "queued");
		pulse(EV_BT, 2);
		rdc(A_BUFUSE, 32'd2, "buffers");
		pulse(EV_BF, 3);
		rdc(A_BUFUSE, 32'd0, "buffers floor");
		// First drop of each route is this port
		ent(0, 64'h020565, 32'h03);
		ent(1, 64'h0, 32'h0);
		ent(10, 64'h01290c0565, 32'h15);
		ent(127, 64'h0807060504030265, 32'h08);
		apb(1'b1, A_TIDX, 32'd10);
		rdc(A_TLO, 32'h290c0565, "entry readback");
		rdc(A_TMETA, 32'h15, "entry type");
		req(8'd1, 1'b0, 1'b0);
		apb(1'b1, A_CFG, 32'h0d);
		req(8'd1, 1'b1, 1'b0);
		chk({fm, flen, froute}, {1'b0, 4'd3, 64'h020565}, "hit route");
		req(8'd2, 1'b0, 1'b1);
		req(8'd11, 1'b1, 1'b0);
		chk({fm, flen, froute}, {1'b1, 4'd5, 64'h01290c0565}, "modbus hit");
		req(8'd0, 1'b0, 1'b1);
		req(8'd129, 1'b0, 1'b1);
		req(8'd128, 1'b1, 1'b0);
		chk({flen, froute}, {4'd8, 64'h0807060504030265}, "last entry");
		apb(1'b1, A_START, 32'hc8);
		rdc(A_START, 32'h81, "start clamp");
		req(8'd129, 1'b1, 1'b0);
		chk(froute, 64'h020565, "shifted window");
		req(8'd1, 1'b0, 1'b1);
		pulse(EV_ERR, 1);
		#1;
		chk({fr, fg}, 2'b11, "lamps lit");
		// Hold is 20 clocks after the strobe edge: lit at the 19th, dark at the 20th
		repeat (19) @(posedge clk);
		#1;
		chk({fr, fg}, 2'b11, "lamps still lit");
		@(posedge clk);
		#1;
		chk({fr, fg}, 2'b00, "lamps out");
		tally_and_finish();
	end
endmodule : tb_top
